// *** rtl/imp_bank.sv ***
// Interrupt enable and priority register bank with request gating and preemption.
// Assumes peripherals give level request flags and the core pulses i_* ack inputs on vectoring.
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/10ps
module imp_bank (
    input  wire logic                       i_clk,           // System clock, 50 MHz
    input  wire logic                       i_reset_n,       // Synchronous reset, active low
    input  wire logic [imp_pkg::IMP_AW-1:0] i_address,       // Avalon byte address
    input  wire logic                       i_read,          // Avalon read
    input  wire logic                       i_write,         // Avalon write
    input  wire logic [3:0]                 i_byteenable,    // Avalon byte enables
    input  wire logic [imp_pkg::IMP_DW-1:0] i_writedata,     // Avalon write data
    output logic      [imp_pkg::IMP_DW-1:0] o_readdata,      // Avalon read data
    output logic                            o_waitrequest,   // Avalon wait request
    output logic                            o_response_err,  // Unmapped access this cycle
    input  wire imp_pkg::imp_basic_t        i_basic_flags,   // Basic source flags (timers 0 and 2 from below)
    input  wire logic                       i_timer2_low_overflow_flag,  // Timer 2 low byte overflow
    input  wire logic                       i_timer2_high_overflow_flag, // Timer 2 high byte overflow
    input  wire logic                       i_timer0_overflow_set, // Timer 0 overflow pulse
    input  wire imp_pkg::imp_ext_t          i_ext_flags,     // Extended source flags
    input  wire logic                       i_vector_taken,  // Core vectors this cycle
    input  wire logic [3:0]                 i_vector_src,    // Source index vectored to
    input  wire logic                       i_reti,          // Return from service routine
    output imp_pkg::imp_req_t               o_req,           // Qualified requests per level
    output logic                            o_irq_low,       // Low level request to core
    output logic                            o_irq_high,      // High level request (may preempt)
    output logic                            o_timer0_overflow_flag // Timer 0 flag state
);
    import imp_pkg::*;

    localparam logic [3:0] SRC_T0 = 4'h1;

    typedef enum logic [1:0] {
        IMP_IDLE = 2'b00,
        IMP_LOW  = 2'b01,
        IMP_HIGH = 2'b10,
        IMP_BOTH = 2'b11
    } imp_svc_t;

    logic [7:0]          enable_r;
    logic [7:0]          prio1_r;
    logic [7:0]          prio2_r;
    logic                t0_flag_r;
    logic [IMP_DW-1:0]   rdata_r;
    logic                ack_r;
    imp_svc_t            svc_r;
    imp_svc_t            svc_nxt;
    logic [IMP_NSRC-1:0] pend;
    logic [IMP_NSRC-1:0] prio_vec;
    logic [7:0]          widx;
    logic                hit;
    logic                req;
    logic                wr_en;

    function automatic logic [7:0] word_idx(input logic [IMP_AW-1:0] a);
        word_idx = a[IMP_AW-1:2];
    endfunction

    function automatic logic mapped(input logic [7:0] idx);
        mapped = (idx == IMP_IDX_ENABLE) || (idx == IMP_IDX_PRIO1) || (idx == IMP_IDX_PRIO2)
              || (idx == IMP_IDX_FLAGS) || (idx == IMP_IDX_CTRL);
    endfunction

    assign widx  = word_idx(i_address);
    assign hit   = mapped(widx);
    assign req   = (i_read || i_write) && !ack_r;
    // Writes land only at the edge where waitrequest is seen low, as the master expects
    assign wr_en = ack_r && i_write && i_byteenable[0];

    // One wait cycle: answer on the second cycle of each request
    assign o_waitrequest  = (i_read || i_write) && !ack_r;
    assign o_response_err = ack_r && !hit;
    assign o_readdata     = rdata_r;

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            enable_r <= IMP_RST_BYTE;
        end else if (wr_en && widx == IMP_IDX_ENABLE) begin
            enable_r <= i_writedata[7:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            prio1_r <= IMP_RST_BYTE;
            prio2_r <= IMP_RST_BYTE;
        end else if (wr_en) begin
            if (widx == IMP_IDX_PRIO1) begin
                // Top two bits are write-only reserved; software writes zero, not stored
                prio1_r <= i_writedata[7:0] & IMP_PRIO1_MASK;
            end
            if (widx == IMP_IDX_PRIO2) begin
                prio2_r <= i_writedata[7:0] & IMP_PRIO2_MASK;
            end
        end
    end

    // Hardware set wins over a software clear or vector clear in the same cycle
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            t0_flag_r <= 1'b0;
        end else if (i_timer0_overflow_set) begin
            t0_flag_r <= 1'b1;
        end else if (i_vector_taken && i_vector_src == SRC_T0) begin
            t0_flag_r <= 1'b0;
        end else if (wr_en && widx == IMP_IDX_CTRL && i_writedata[IMP_SET_T0_BIT]) begin
            t0_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            rdata_r <= '0;
        end else if (req && i_read) begin
            case (widx)
                IMP_IDX_ENABLE: rdata_r <= {24'h000000, enable_r};
                IMP_IDX_PRIO1:  rdata_r <= {24'h000000, prio1_r};
                IMP_IDX_PRIO2:  rdata_r <= {24'h000000, prio2_r & IMP_PRIO2_MASK};
                IMP_IDX_FLAGS:  rdata_r <= {17'h00000, pend};
                IMP_IDX_CTRL:   rdata_r <= {22'h000000, svc_r, 7'h00, t0_flag_r};
                default:        rdata_r <= '0;
            endcase
        end
    end

    always_comb begin
        pend = '0;
        pend[IMP_X0_BIT] = i_basic_flags.ext_input0 && enable_r[IMP_X0_BIT];
        pend[IMP_T0_BIT] = t0_flag_r && enable_r[IMP_T0_BIT];
        pend[IMP_X1_BIT] = i_basic_flags.ext_input1 && enable_r[IMP_X1_BIT];
        pend[IMP_T1_BIT] = i_basic_flags.timer1 && enable_r[IMP_T1_BIT];
        pend[IMP_UART_BIT] = i_basic_flags.uart && enable_r[IMP_UART_BIT];
        pend[IMP_T2_BIT] = (i_timer2_low_overflow_flag || i_timer2_high_overflow_flag)
                         && enable_r[IMP_T2_BIT];
        pend[IMP_SPI_BIT] = i_basic_flags.spi && enable_r[IMP_SPI_BIT];
        // Extended sources have no mask bit here; only the global gate applies
        pend[IMP_NSRC-1:IMP_EXT_BASE] = i_ext_flags;
        if (!enable_r[IMP_GATE_BIT]) begin
            pend = '0;
        end
    end

    // Basic sources sit at low level; extended levels from the priority registers
    assign prio_vec = {prio2_r[1], prio2_r[0],
                       prio1_r[5], prio1_r[4], prio1_r[3],
                       prio1_r[2], prio1_r[1], prio1_r[0],
                       7'h00};

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_req <= '0;
        end else begin
            o_req.high <= pend & prio_vec;
            o_req.low  <= pend & ~prio_vec;
        end
    end

    // Tracks nesting: low may be interrupted by high, never the reverse
    always_comb begin
        svc_nxt = svc_r;
        case (svc_r)
            IMP_IDLE: if (i_vector_taken) svc_nxt = (|o_req.high) ? IMP_HIGH : IMP_LOW;
            IMP_LOW:  if (i_vector_taken) svc_nxt = IMP_BOTH;
                      else if (i_reti) svc_nxt = IMP_IDLE;
            IMP_HIGH: if (i_reti) svc_nxt = IMP_IDLE;
            IMP_BOTH: if (i_reti) svc_nxt = IMP_LOW;
            default:  svc_nxt = IMP_IDLE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            svc_r <= IMP_IDLE;
        end else begin
            svc_r <= svc_nxt;
        end
    end

    assign o_irq_high = (|o_req.high) && (svc_r == IMP_IDLE || svc_r == IMP_LOW);
    assign o_irq_low  = (|o_req.low) && (svc_r == IMP_IDLE) && !o_irq_high;
    assign o_timer0_overflow_flag = t0_flag_r;
endmodule

// *** rtl/imp_pkg.sv ***
// Package for the interrupt mask and priority bank: register map, field positions, carriers.
// Assumes an Avalon-MM slave with registers placed one per aligned word; enable and priority registers are byte-wide.
package imp_pkg;
    localparam int unsigned IMP_AW = 10;
    localparam int unsigned IMP_DW = 32;
    // Printed offsets are not all multiples of four, so each is a word index
    localparam logic [7:0] IMP_IDX_ENABLE  = 8'hA8;
    localparam logic [7:0] IMP_IDX_PRIO1   = 8'hF3;
    localparam logic [7:0] IMP_IDX_PRIO2   = 8'hF4;
    localparam logic [7:0] IMP_IDX_FLAGS   = 8'h10;
    localparam logic [7:0] IMP_IDX_CTRL    = 8'h11;
    localparam logic [7:0] IMP_RST_BYTE    = 8'h00;
    localparam logic [7:0] IMP_PRIO2_MASK  = 8'h03;
    localparam logic [7:0] IMP_PRIO1_MASK  = 8'h3F;
    localparam int unsigned IMP_GATE_BIT   = 7;
    localparam int unsigned IMP_SPI_BIT    = 6;
    localparam int unsigned IMP_T2_BIT     = 5;
    localparam int unsigned IMP_UART_BIT   = 4;
    localparam int unsigned IMP_T1_BIT     = 3;
    localparam int unsigned IMP_X1_BIT     = 2;
    localparam int unsigned IMP_T0_BIT     = 1;
    localparam int unsigned IMP_X0_BIT     = 0;
    localparam int unsigned IMP_NSRC       = 15;
    localparam int unsigned IMP_EXT_BASE   = 7;
    localparam int unsigned IMP_SET_T0_BIT = 0;

    // Basic sources, ordered as their mask bits 0..6
    typedef struct packed {
        logic spi;
        logic timer2;
        logic uart;
        logic timer1;
        logic ext_input1;
        logic timer0;
        logic ext_input0;
    } imp_basic_t;

    // Extended sources, ordered as priority bits
    typedef struct packed {
        logic capsense_greater;
        logic capsense_done;
        logic analog_comparator;
        logic counter_array;
        logic adc_done;
        logic adc_window;
        logic port_match;
        logic smbus_unit;
    } imp_ext_t;

    typedef struct packed {
        logic [IMP_NSRC-1:0] high;
        logic [IMP_NSRC-1:0] low;
    } imp_req_t;
endpackage

// *** dv/imp_bank_sva.sv ***
// Checker for the mask and priority bank: bus timing, request causes, timer 0 flag.
// Assumes the bus master holds each request until waitrequest drops.
`timescale 1ns/10ps
module imp_bank_chk import imp_pkg::*; (
    input wire logic       i_clk,
    input wire logic       i_reset_n,
    input wire logic       i_read,
    input wire logic       i_write,
    input wire imp_basic_t i_basic_flags,
    input wire logic       i_timer0_overflow_set,
    input wire logic       i_vector_taken,
    input wire logic [3:0] i_vector_src,
    input wire logic       o_waitrequest,
    input wire logic       o_response_err,
    input wire imp_req_t   o_req,
    input wire logic       o_irq_low,
    input wire logic       o_irq_high,
    input wire logic       o_timer0_overflow_flag
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    sequence req_rise; (i_read || i_write) && !$past(i_read || i_write); endsequence
    sequence req_wait; (i_read || i_write) && o_waitrequest; endsequence
    wait_first_a: assert property (req_rise |-> o_waitrequest) else $error("no wait cycle");
    wait_one_a: assert property (req_wait |=> !o_waitrequest) else $error("wait too long");
    err_answer_a: assert property (o_response_err |-> (i_read || i_write) && !o_waitrequest)
        else $error("stray error flag");
    t0_set_a: assert property (i_timer0_overflow_set |=> o_timer0_overflow_flag) else $error("flag not set");
    t0_vector_a: assert property (i_vector_taken && i_vector_src == 4'h1 && !i_timer0_overflow_set
        |=> !o_timer0_overflow_flag) else $error("flag kept after vector");
    high_cause_a: assert property (o_irq_high |-> |o_req.high) else $error("high irq without cause");
    low_cause_a: assert property (o_irq_low |-> |o_req.low) else $error("low irq without cause");
    one_level_a: assert property ((o_req.high & o_req.low) == '0) else $error("two levels at once");
    t0_req_a: assert property (o_req.low[1] |-> $past(o_timer0_overflow_flag)) else $error("t0 req");
    x0_req_a: assert property (o_req.low[0] |-> $past(i_basic_flags.ext_input0)) else $error("x0 req");
endmodule
bind imp_bank imp_bank_chk u_chk (.i_clk, .i_reset_n, .i_read, .i_write, .i_basic_flags, .i_timer0_overflow_set,
    .i_vector_taken, .i_vector_src, .o_waitrequest, .o_response_err, .o_req, .o_irq_low, .o_irq_high,
    .o_timer0_overflow_flag);

// *** dv/imp_core_model.sv ***
// Core model: vectors to one armed source, returns three cycles later.
// Assumes the bench chooses the source index and arms it.
`timescale 1ns/10ps
module imp_core_model (
    input  wire logic       i_clk,      // System clock
    input  wire logic       i_reset_n,  // Synchronous reset, active low
    input  wire logic       i_arm,      // Allow vectoring
    input  wire logic [3:0] i_src,      // Source to vector to
    input  wire logic       i_irq_low,  // Low level request
    input  wire logic       i_irq_high, // High level request
    output logic            o_vector_taken, // Vector pulse
    output logic [3:0]      o_vector_src,   // Vectored source
    output logic            o_reti          // Return pulse
);
    logic [1:0] left_r;
    initial begin
        o_vector_taken = 1'b0;
        o_vector_src = 4'h0;
        o_reti = 1'b0;
    end
    always @(posedge i_clk) begin
        o_vector_taken <= 1'b0;
        o_reti <= 1'b0;
        // Idle index is scrambled so a stale source is never trusted
        o_vector_src <= ~i_src;
        if (!i_reset_n) begin
            left_r <= 2'h0;
        end else if (left_r != 2'h0) begin
            left_r <= left_r - 2'h1;
            o_reti <= (left_r == 2'h1);
        end else if (i_arm && (i_irq_low || i_irq_high)) begin
            o_vector_taken <= 1'b1;
            o_vector_src <= i_src;
            left_r <= 2'h3;
        end
    end
endmodule

// *** dv/testbench.sv ***
// Self-checking bench for the bank: Avalon register access, gating, priority, timer 0 flag.
// Assumes one wait cycle per access and the core model in dv/.
`timescale 1ns/10ps
module testbench;
    import imp_pkg::*;
    localparam logic [9:0] EN = {IMP_IDX_ENABLE, 2'b00}, P1 = {IMP_IDX_PRIO1, 2'b00};
    localparam logic [9:0] P2 = {IMP_IDX_PRIO2, 2'b00}, FL = {IMP_IDX_FLAGS, 2'b00}, CT = {IMP_IDX_CTRL, 2'b00};
    logic i_clk = 0, i_reset_n = 0, i_read = 0, i_write = 0, t0_set = 0, t2l = 0, t2h = 0, arm = 0, snap = 0;
    logic [9:0] addr = '0;
    logic [31:0] wdata = '0, rdata, r;
    logic [7:0] m;
    logic [3:0] vsrc;
    logic wreq, err, vec, reti, irq_l, irq_h, t0f;
    imp_basic_t basic = '0;
    imp_ext_t ext = '0;
    imp_req_t req;
    logic [31:0] rq[$];
    logic [14:0] hq[$];
    logic [14:0] he;
    int failures = 0, checks_done = 0;
    imp_bank dut (.i_clk, .i_reset_n, .i_address(addr), .i_read, .i_write, .i_byteenable(4'hF),
        .i_writedata(wdata), .o_readdata(rdata), .o_waitrequest(wreq), .o_response_err(err),
        .i_basic_flags(basic), .i_timer2_low_overflow_flag(t2l), .i_timer2_high_overflow_flag(t2h),
        .i_timer0_overflow_set(t0_set), .i_ext_flags(ext), .i_vector_taken(vec), .i_vector_src(vsrc),
        .i_reti(reti), .o_req(req), .o_irq_low(irq_l), .o_irq_high(irq_h), .o_timer0_overflow_flag(t0f));
    imp_core_model core (.i_clk, .i_reset_n, .i_arm(arm), .i_src(4'h1), .i_irq_low(irq_l),
        .i_irq_high(irq_h), .o_vector_taken(vec), .o_vector_src(vsrc), .o_reti(reti));
    initial forever #10 i_clk = ~i_clk;
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
        checks_done++;
        if (s !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    always @(posedge i_clk) begin
        if (i_read && wreq === 1'b0) cmp("readdata", rq.pop_front(), rdata);
        if (snap) begin
            he = hq.pop_front();
            cmp("req_high", {17'h0, he}, {17'h0, req.high});
            cmp("irq_high", {31'h0, |he}, {31'h0, irq_h});
            cmp("irq_low", 32'h0, {31'h0, irq_l});
        end
    end
    task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d, input logic [31:0] e);
        if (!wr) rq.push_back(e);
        i_read <= !wr;
        i_write <= wr;
        addr <= a;
        wdata <= d;
        do @(posedge i_clk); while (wreq !== 1'b0);
        cmp("response_err", {31'h0, !(a[9:2] inside {IMP_IDX_ENABLE, IMP_IDX_PRIO1, IMP_IDX_PRIO2,
            IMP_IDX_FLAGS, IMP_IDX_CTRL})}, {31'h0, err});
        i_read <= 1'b0;
        i_write <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic peek(input logic [14:0] e);
        hq.push_back(e);
        snap <= 1'b1;
        @(posedge i_clk);
        snap <= 1'b0;
    endtask
    task automatic pulse_t0;
        t0_set <= 1'b1;
        @(posedge i_clk);
        t0_set <= 1'b0;
    endtask
    task tally_and_finish;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge i_clk);
        failures++;
        tally_and_finish();
    end
    initial begin
        r = $urandom(9);
        repeat (12) @(posedge i_clk);
        i_reset_n <= 1'b1;
        @(posedge i_clk);
        bus(0, EN, 0, 0);
        bus(0, P1, 0, 0);
        bus(0, P2, 0, 0);
        r = $urandom;
        bus(1, EN, r, 0);
        bus(0, EN, 0, {24'h0, r[7:0]});
        bus(1, P1, 32'h3F, 0);
        bus(0, P1, 0, 32'h3F);
        bus(1, P2, 32'hFF, 0);
        bus(0, P2, 0, 32'h03);
        bus(0, 10'h3FC, 0, 0);
        bus(1, P1, 0, 0);
        bus(1, P2, 0, 0);
        $display("test registers done");
        basic <= '1;
        pulse_t0();
        for (int i = 0; i < 9; i++) begin
            m = (i < 7) ? (8'h80 | (8'h01 << i)) : ((i == 7) ? 8'h7F : 8'hFF);
            r = $urandom;
            t2l <= r[0];
            t2h <= ~r[0];
            bus(1, EN, {24'h0, m}, 0);
            bus(0, FL, 0, m[7] ? {25'h0, m[6:0]} : 0);
        end
        $display("test gating done");
        ext <= '1;
        bus(1, EN, 32'h80, 0);
        for (int b = 0; b < 8; b++) begin
            bus(1, (b < 6) ? P1 : P2, 32'h1 << ((b < 6) ? b : b - 6), 0);
            peek(15'h1 << (b + 7));
            bus(1, (b < 6) ? P1 : P2, 0, 0);
        end
        $display("test priority done");
        ext <= '0;
        basic <= '0;
        bus(1, EN, 32'h82, 0);
        bus(0, CT, 0, 1);
        arm <= 1'b1;
        repeat (6) @(posedge i_clk);
        arm <= 1'b0;
        bus(0, CT, 0, 0);
        pulse_t0();
        bus(1, CT, 1, 0);
        bus(0, CT, 0, 0);
        $display("test timer0 done");
        tally_and_finish();
    end
endmodule
